// File: logic/timer_capture_overflow.sv
// Function
// - Counter wrap from max to zero sets flag
// - Flag clears only on zero write after read
// - Writing one to flag bits does nothing
// - Falling capture edge latches count, reset zero
// - Rising capture edge latches count, read-only
`timescale 1ns/10ps
`default_nettype none
module timer_capture_overflow
    import capture_timer_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    input  wire logic [7:0]        capture_timer_count,
    input  wire logic              capture_input,
    input  wire logic              low_overflow_event,
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [7:0]        rdata,
    output logic                   irq,
    output logic      [CTRL_W-1:0] mode_ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]        mode_r;
    logic [7:0]        mode_nxt;
    logic [FLAG_W-1:0] arm_r;
    logic [FLAG_W-1:0] arm_nxt;
    logic [7:0]        prev_count_r;
    logic              prev_cap_r;
    logic [7:0]        fall_cap_r;
    logic [7:0]        rise_cap_r;
    logic [EV_W-1:0]   stat_r;
    logic [EV_W-1:0]   stat_nxt;
    logic [EV_W-1:0]   mask_r;
    logic [EV_W-1:0]   mask_nxt;
    logic [7:0]        rdata_r;
    logic              irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_mode = wr && (addr == OFS_MODE);
    wire rd_mode = rd && (addr == OFS_MODE);
    wire wr_mask = wr && (addr == OFS_IRQ_MASK);
    wire rd_stat = rd && (addr == OFS_IRQ_STAT);

    wire [7:0] rd_mux =
        (addr == OFS_MODE)     ? mode_r :
        (addr == OFS_FALL_CAP) ? fall_cap_r :
        (addr == OFS_RISE_CAP) ? rise_cap_r :
        (addr == OFS_IRQ_STAT) ? {{(8-EV_W){1'b0}}, stat_r} :
        (addr == OFS_IRQ_MASK) ? {{(8-EV_W){1'b0}}, mask_r} :
                                 RDATA_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Event detection; inputs are already in this clock domain
    wire ovf_set   = (prev_count_r == COUNT_MAX) && (capture_timer_count == COUNT_ZERO);
    wire fall_edge = prev_cap_r && !capture_input;
    wire rise_edge = !prev_cap_r && capture_input;

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flags with read-then-write-zero clearing
    wire [FLAG_W-1:0] flag_cur = mode_r[HIGH_OVF_BIT:LOW_OVF_BIT];
    wire [FLAG_W-1:0] flag_set = {ovf_set, low_overflow_event};
    // A clear needs the arm left by an earlier read that saw the flag high
    wire [FLAG_W-1:0] clr_ok   = {FLAG_W{wr_mode}} & ~wdata[HIGH_OVF_BIT:LOW_OVF_BIT] & arm_r;
    // Ones written to the flags are simply dropped here
    wire [FLAG_W-1:0] flag_nxt = flag_set | (flag_cur & ~clr_ok);

    // Arm drops with the clear, so a set that wins needs a fresh read
    assign arm_nxt  = ((arm_r & ~clr_ok) | ({FLAG_W{rd_mode}} & flag_cur)) & flag_nxt;
    assign mode_nxt = {flag_nxt, wr_mode ? wdata[CTRL_W-1:0] : mode_r[CTRL_W-1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, cleared by reading it; new events win
    wire [EV_W-1:0] events;
    assign events[EV_OVF_BIT]  = ovf_set;
    assign events[EV_FALL_BIT] = fall_edge;
    assign events[EV_RISE_BIT] = rise_edge;

    assign stat_nxt = events | (stat_r & ~{EV_W{rd_stat}});
    assign mask_nxt = wr_mask ? wdata[EV_W-1:0] : mask_r;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= MODE_RESET;
            arm_r  <= '0;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
            arm_r  <= arm_nxt;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_count_r <= COUNT_ZERO;
            prev_cap_r   <= 1'b0;
        end else if (clk_en) begin
            prev_count_r <= capture_timer_count;
            prev_cap_r   <= capture_input;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fall_cap_r <= CAP_RESET;
        end else if (clk_en && fall_edge) begin
            fall_cap_r <= capture_timer_count;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rise_cap_r <= CAP_RESET;
        end else if (clk_en && rise_edge) begin
            rise_cap_r <= capture_timer_count;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= EV_RESET;
            mask_r <= EV_RESET;
            irq_r  <= 1'b0;
        end else if (clk_en) begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= |(stat_nxt & mask_nxt);
        end
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= RDATA_IDLE;
        end else if (clk_en) begin
            rdata_r <= rd ? rd_mux : RDATA_IDLE;
        end
    end

    assign rdata     = rdata_r;
    assign irq       = irq_r;
    assign mode_ctrl = mode_r[CTRL_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    AST_OVF_SET: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && prev_count_r == COUNT_MAX && capture_timer_count == COUNT_ZERO) |=> mode_r[HIGH_OVF_BIT])
        else $error("overflow did not set the high flag");

    AST_NO_CLEAR_UNARMED: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mode && !wdata[HIGH_OVF_BIT] && !arm_r[1] && mode_r[HIGH_OVF_BIT]) |=> mode_r[HIGH_OVF_BIT])
        else $error("flag cleared without a prior read");

    AST_CLEAR_ARMED: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rd_mode && mode_r[HIGH_OVF_BIT] && !ovf_set)
        ##1 (clk_en && wr_mode && !wdata[HIGH_OVF_BIT] && !ovf_set) |=> !mode_r[HIGH_OVF_BIT])
        else $error("read then zero write did not clear the flag");

    AST_ONE_WRITE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mode && wdata[LOW_OVF_BIT] && !mode_r[LOW_OVF_BIT] && !low_overflow_event)
        |=> !mode_r[LOW_OVF_BIT])
        else $error("writing one changed a flag");

    AST_FALL_CAP: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && prev_cap_r && !capture_input) |=> (fall_cap_r == $past(capture_timer_count)))
        else $error("falling edge capture mismatch");

    AST_RISE_CAP: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && !prev_cap_r && capture_input) |=> (rise_cap_r == $past(capture_timer_count)))
        else $error("rising edge capture mismatch");

    // The arm is already gone one edge after the collision; a later read may re-arm it
    AST_SET_WINS: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && ovf_set && wr_mode && !rd && !wdata[HIGH_OVF_BIT])
        |=> (mode_r[HIGH_OVF_BIT] && !arm_r[FLAG_W-1]))
        else $error("overflow lost against a clearing write");

    AST_SET_WINS_LOW: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && low_overflow_event && wr_mode && !rd && !wdata[LOW_OVF_BIT])
        |=> (mode_r[LOW_OVF_BIT] && !arm_r[0]))
        else $error("low flag event lost against a clearing write");

    ////////////////////////////////////////////////////////////////////////////
    // Flag, arm and control bit bookkeeping
    AST_ARM_SET: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rd_mode && !wr && mode_r[HIGH_OVF_BIT])
        |=> arm_r[FLAG_W-1])
        else $error("reading a set flag did not arm its clear");

    AST_ARM_NEEDS_FLAG: assert property (@(posedge clock) disable iff (!arst_n)
        arm_r[FLAG_W-1]
        |-> mode_r[HIGH_OVF_BIT])
        else $error("clear armed while the flag is low");

    AST_CLEAR_DROPS_ARM: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mode && !wdata[HIGH_OVF_BIT] && arm_r[FLAG_W-1] && !ovf_set)
        |=> (!mode_r[HIGH_OVF_BIT] && !arm_r[FLAG_W-1]))
        else $error("armed zero write did not clear the flag and arm");

    AST_LOW_SET: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && low_overflow_event)
        |=> mode_r[LOW_OVF_BIT])
        else $error("low flag event did not set its flag");

    AST_LOW_CLEAR_ARMED: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rd_mode && !wr && mode_r[LOW_OVF_BIT] && !low_overflow_event)
        ##1 (clk_en && wr_mode && !wdata[LOW_OVF_BIT] && !low_overflow_event) |=> !mode_r[LOW_OVF_BIT])
        else $error("read then zero write did not clear the low flag");

    AST_HIGH_ONLY_BY_OVF: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && !mode_r[HIGH_OVF_BIT] && !ovf_set)
        |=> !mode_r[HIGH_OVF_BIT])
        else $error("high flag rose without an overflow");

    AST_ONE_WRITE_HIGH: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mode && wdata[HIGH_OVF_BIT] && !mode_r[HIGH_OVF_BIT] && !ovf_set)
        |=> !mode_r[HIGH_OVF_BIT])
        else $error("writing one set the high flag");

    AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mode)
        |=> (mode_ctrl == $past(wdata[CTRL_W-1:0])))
        else $error("mode control bits did not take the write");

    AST_CTRL_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        !(clk_en && wr_mode)
        |=> $stable(mode_ctrl))
        else $error("mode control bits changed without a write");

    ////////////////////////////////////////////////////////////////////////////
    // Capture registers only move on their own edge, never by a bus write
    AST_FALL_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        !(clk_en && fall_edge)
        |=> $stable(fall_cap_r))
        else $error("falling capture changed without a falling edge");

    AST_RISE_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        !(clk_en && rise_edge)
        |=> $stable(rise_cap_r))
        else $error("rising capture changed without a rising edge");

    AST_RISE_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr && (addr == OFS_RISE_CAP) && !rise_edge)
        |=> $stable(rise_cap_r))
        else $error("a write reached the rising capture register");

    AST_PREV_CAP: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en
        |=> (prev_cap_r == $past(capture_input)))
        else $error("capture edge detector lost its sample");

    ////////////////////////////////////////////////////////////////////////////
    // Read port, status, mask and interrupt
    AST_RDATA_READ: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rd)
        |=> (rdata == $past(rd_mux)))
        else $error("read data did not follow the strobe");

    AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && !rd)
        |=> (rdata == RDATA_IDLE))
        else $error("read data stood without a strobe");

    AST_STAT_STICKY: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && !rd_stat)
        |=> ((stat_r & $past(stat_r)) == $past(stat_r)))
        else $error("status bit dropped without a read");

    AST_STAT_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rd_stat && !ovf_set && !fall_edge && !rise_edge)
        |=> (stat_r == EV_RESET))
        else $error("status read did not clear it");

    AST_STAT_OVF: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && ovf_set)
        |=> stat_r[EV_OVF_BIT])
        else $error("overflow did not set its status bit");

    AST_STAT_FALL: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && fall_edge)
        |=> stat_r[EV_FALL_BIT])
        else $error("falling edge did not set its status bit");

    AST_STAT_RISE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && rise_edge)
        |=> stat_r[EV_RISE_BIT])
        else $error("rising edge did not set its status bit");

    AST_MASK_WRITE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && wr_mask)
        |=> (mask_r == $past(wdata[EV_W-1:0])))
        else $error("mask did not take the write");

    AST_MASK_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        !(clk_en && wr_mask)
        |=> $stable(mask_r))
        else $error("mask changed without a write");

    AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (!arst_n)
        irq
        == (|(stat_r & mask_r)))
        else $error("interrupt level disagrees with status and mask");

    // A low enable must hold everything, edge detector included, or edges get lost
    AST_FREEZE: assert property (@(posedge clock) disable iff (!arst_n)
        !clk_en
        |=> ($stable(mode_r) && $stable(arm_r) && $stable(stat_r) && $stable(rdata_r) && $stable(prev_cap_r)))
        else $error("state moved while the clock enable was low");

endmodule // timer_capture_overflow
`default_nettype wire

// File: logic/capture_timer_pkg.sv
`default_nettype none
package capture_timer_pkg;
    // Register offsets on the internal byte bus
    localparam logic [7:0] OFS_MODE      = 8'hbc;
    localparam logic [7:0] OFS_FALL_CAP  = 8'hbd;
    localparam logic [7:0] OFS_RISE_CAP  = 8'hbe;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'hf0;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'hf1;

    // Mode register layout: two flags on top, plain control below
    localparam int         HIGH_OVF_BIT  = 7;
    localparam int         LOW_OVF_BIT   = 6;
    localparam int         CTRL_W        = 6;
    localparam int         FLAG_W        = 2;

    // Interrupt status and mask layout
    localparam int         EV_OVF_BIT    = 0;
    localparam int         EV_FALL_BIT   = 1;
    localparam int         EV_RISE_BIT   = 2;
    localparam int         EV_W          = 3;

    localparam logic [7:0] COUNT_MAX     = 8'hff;
    localparam logic [7:0] COUNT_ZERO    = 8'h00;

    localparam logic [7:0]        MODE_RESET = 8'h00;
    localparam logic [7:0]        CAP_RESET  = 8'h00;
    localparam logic [EV_W-1:0]   EV_RESET   = 3'h0;
    localparam logic [7:0]        RDATA_IDLE = 8'h00;
endpackage
`default_nettype wire

// File: sim/timer_capture_overflow_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
        failures++; \
    end
module timer_capture_overflow_tb import capture_timer_pkg::*;;
    logic              clock               = 1'b0;
    logic              arst_n              = 1'b0;
    logic              clk_en              = 1'b1;
    logic              capture_input       = 1'b0;
    logic              low_overflow_event  = 1'b0;
    logic              wr                  = 1'b0;
    logic              rd                  = 1'b0;
    logic [7:0]        capture_timer_count = 8'h00;
    logic [7:0]        addr                = 8'h00;
    logic [7:0]        wdata               = 8'h00;
    logic [7:0]        rdata;
    logic              irq;
    logic [CTRL_W-1:0] mode_ctrl;
    int                failures            = 0;
    int                samples_checked     = 0;

    always #25 clock = ~clock;

    timer_capture_overflow dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .capture_timer_count(capture_timer_count), .capture_input(capture_input),
        .low_overflow_event(low_overflow_event), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .mode_ctrl(mode_ctrl));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask

    // Read data only stands in the cycle after the strobe, so look just past that edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    task automatic report_and_stop;
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(OFS_FALL_CAP, CAP_RESET);
        rd_chk(8'h55, RDATA_IDLE);
        wr_reg(OFS_MODE, 8'hc0);
        rd_chk(OFS_MODE, 8'h00);
        // Walk the counter through its wrap point
        foreach (capture_timer_count[i]) begin
            @(posedge clock);
            capture_timer_count <= 8'hf8 + 8'(7 - i);
        end
        @(posedge clock);
        capture_timer_count <= 8'h00;
        repeat (3) @(posedge clock);
        #1;
        `CHK("irq", 1'b0, irq)
        wr_reg(OFS_MODE, 8'h00);
        rd_chk(OFS_MODE, 8'h80);
        wr_reg(OFS_MODE, 8'hff);
        rd_chk(OFS_MODE, 8'hbf);
        `CHK("mode_ctrl", 6'h3f, mode_ctrl)
        wr_reg(OFS_MODE, 8'h00);
        rd_chk(OFS_MODE, 8'h00);
        rd_chk(OFS_IRQ_STAT, 8'h01);
        // Count and capture change together so each edge sees a distinct value
        @(posedge clock);
        capture_timer_count <= 8'h5a;
        capture_input <= 1'b1;
        @(posedge clock);
        capture_timer_count <= 8'ha5;
        capture_input <= 1'b0;
        @(posedge clock);
        capture_timer_count <= 8'h10;
        wr_reg(OFS_IRQ_MASK, 8'h06);
        `CHK("irq", 1'b1, irq)
        rd_chk(OFS_IRQ_MASK, 8'h06);
        rd_chk(OFS_RISE_CAP, 8'h5a);
        rd_chk(OFS_FALL_CAP, 8'ha5);
        wr_reg(OFS_RISE_CAP, 8'h33);
        rd_chk(OFS_RISE_CAP, 8'h5a);
        rd_chk(OFS_IRQ_STAT, 8'h06);
        `CHK("irq", 1'b0, irq)
        // Unmasked overflow raises the interrupt
        wr_reg(OFS_IRQ_MASK, 8'h01);
        @(posedge clock);
        capture_timer_count <= 8'hff;
        @(posedge clock);
        capture_timer_count <= 8'h00;
        repeat (2) @(posedge clock);
        #1;
        `CHK("irq", 1'b1, irq)
        rd_chk(OFS_MODE, 8'h80);
        // Armed clearing write lands in the same cycle as a new wrap
        @(posedge clock);
        capture_timer_count <= 8'hff;
        @(posedge clock);
        capture_timer_count <= 8'h00;
        wr <= 1'b1;
        addr <= OFS_MODE;
        wdata <= 8'h00;
        @(posedge clock);
        wr <= 1'b0;
        rd_chk(OFS_MODE, 8'h80);
        wr_reg(OFS_MODE, 8'h00);
        rd_chk(OFS_MODE, 8'h00);
        rd_chk(OFS_IRQ_STAT, 8'h01);
        `CHK("irq", 1'b0, irq)
        // Enable low: a capture edge must not be seen
        @(posedge clock);
        clk_en <= 1'b0;
        capture_input <= 1'b1;
        capture_timer_count <= 8'h77;
        repeat (3) @(posedge clock);
        clk_en <= 1'b1;
        capture_input <= 1'b0;
        rd_chk(OFS_RISE_CAP, 8'h5a);
        // Companion flag: set by its event, cleared only after a read
        @(posedge clock);
        low_overflow_event <= 1'b1;
        @(posedge clock);
        low_overflow_event <= 1'b0;
        wr_reg(OFS_MODE, 8'h00);
        rd_chk(OFS_MODE, 8'h40);
        wr_reg(OFS_MODE, 8'h40);
        rd_chk(OFS_MODE, 8'h40);
        wr_reg(OFS_MODE, 8'h00);
        rd_chk(OFS_MODE, 8'h00);
        report_and_stop();
    end
endmodule // timer_capture_overflow_tb
`default_nettype wire
